// ---- design/sdpr_pkg.sv ----
// constants shared by the dual-port burst ram
package sdpr_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 18;
  localparam int BYTE_W = 9;
  localparam int DEPTH = 65536;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam int PIPE_LAT_CYC = 1;
endpackage : sdpr_pkg

// ---- design/sdpr_port.sv ----
// one port front end: input registers and burst address counter
`timescale 1ns/1ns
module sdpr_port (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [sdpr_pkg::ADDR_W-1:0] addr_i,
  input wire logic addr_strobe_n_i,
  input wire logic count_enable_n_i,
  input wire logic counter_clear_n_i,
  input wire logic chip_select_low_n_i,
  input wire logic chip_select_high_i,
  input wire logic write_n_i,
  input wire logic low_byte_select_n_i,
  input wire logic high_byte_select_n_i,
  input wire logic [sdpr_pkg::DATA_W-1:0] wdata_i,
  output logic [sdpr_pkg::ADDR_W-1:0] addr_o,
  output logic sel_o,
  output logic wr_o,
  output logic [1:0] lane_o,
  output logic [sdpr_pkg::DATA_W-1:0] wdata_o
);
  logic [sdpr_pkg::ADDR_W-1:0] cnt_r;
  logic [sdpr_pkg::ADDR_W-1:0] cnt_nxt;
  logic sel_nxt;

  assign sel_nxt = !chip_select_low_n_i && chip_select_high_i;

  // clear beats strobe beats count; wrap comes from natural overflow
  always_comb
  begin
    if (!counter_clear_n_i)
      cnt_nxt = sdpr_pkg::ADDR_RST;
    else if (!addr_strobe_n_i)
      cnt_nxt = addr_i;
    else if (!count_enable_n_i)
      cnt_nxt = cnt_r + 16'h0001;
    else
      cnt_nxt = cnt_r;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_r <= sdpr_pkg::ADDR_RST;
    else
      cnt_r <= cnt_nxt;
  end

  // the access uses the same address the counter takes, so a burst
  // advances one word per edge in either output mode
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      addr_o <= sdpr_pkg::ADDR_RST;
      sel_o <= 1'b0;
      wr_o <= 1'b0;
      lane_o <= 2'h0;
      wdata_o <= sdpr_pkg::DATA_RST;
    end
    else
    begin
      addr_o <= cnt_nxt;
      sel_o <= sel_nxt;
      wr_o <= sel_nxt && !write_n_i;
      lane_o <= {!high_byte_select_n_i, !low_byte_select_n_i};
      wdata_o <= wdata_i;
    end
  end

  a_clear_wins: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !counter_clear_n_i |=> cnt_r == sdpr_pkg::ADDR_RST)
    else $error("counter clear not honoured");
  a_strobe_load: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    counter_clear_n_i && !addr_strobe_n_i |=> cnt_r == $past(addr_i))
    else $error("strobe did not load counter");
  a_count_step: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    counter_clear_n_i && addr_strobe_n_i && !count_enable_n_i
    |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter did not advance");
  a_count_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    counter_clear_n_i && addr_strobe_n_i && count_enable_n_i |=> $stable(cnt_r))
    else $error("counter moved while idle");
  a_deselect_nowr: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !(!chip_select_low_n_i && chip_select_high_i) |=> !wr_o && !sel_o)
    else $error("write while deselected");
  c_burst: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !addr_strobe_n_i ##1 (!count_enable_n_i && addr_strobe_n_i)[*3]);
  c_wrap: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cnt_r == 16'hffff ##1 cnt_r == sdpr_pkg::ADDR_RST);
endmodule : sdpr_port

// ---- design/sdpr_ram.sv ----
// true dual-port burst ram core with pipelined or flow-through reads
`timescale 1ns/1ns
module sdpr_ram (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [1:0] output_mode_select_i,
  input wire logic [2*sdpr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [1:0] addr_strobe_n_i,
  input wire logic [1:0] count_enable_n_i,
  input wire logic [1:0] counter_clear_n_i,
  input wire logic [1:0] chip_select_low_n_i,
  input wire logic [1:0] chip_select_high_i,
  input wire logic [1:0] write_n_i,
  input wire logic [1:0] low_byte_select_n_i,
  input wire logic [1:0] high_byte_select_n_i,
  input wire logic [1:0] output_enable_n_i,
  input wire logic [2*sdpr_pkg::DATA_W-1:0] data_i,
  output logic [2*sdpr_pkg::DATA_W-1:0] data_o,
  output logic [2*sdpr_pkg::DATA_W-1:0] data_oe_o,
  output logic [1:0] powered_down_o
);
  // ****************************************************************
  // storage and per-port front ends
  // ****************************************************************
  // no reset of the array: contents are undefined at power-up
  logic [sdpr_pkg::DATA_W-1:0] mem [0:sdpr_pkg::DEPTH-1];
  logic [sdpr_pkg::ADDR_W-1:0] p_addr [2];
  logic [1:0] p_sel;
  logic [1:0] p_wr;
  logic [1:0] p_lane [2];
  logic [sdpr_pkg::DATA_W-1:0] p_wdata [2];
  logic [sdpr_pkg::DATA_W-1:0] rd_r [2];
  logic [1:0] oen_r;
  logic [1:0] sel_d_r;
  logic [1:0] pipe_sel_r;
  logic [1:0] pipe_rd_r;
  logic [1:0] pipe_lane_r [2];

  function automatic logic [sdpr_pkg::DATA_W-1:0] lane_mask(input logic [1:0] lane);
    lane_mask = {{sdpr_pkg::BYTE_W{lane[1]}}, {sdpr_pkg::BYTE_W{lane[0]}}};
  endfunction : lane_mask

  for (genvar p = 0; p < 2; p++)
  begin : g_port
    sdpr_port u_port (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .addr_i(addr_i[p*sdpr_pkg::ADDR_W +: sdpr_pkg::ADDR_W]),
      .addr_strobe_n_i(addr_strobe_n_i[p]),
      .count_enable_n_i(count_enable_n_i[p]),
      .counter_clear_n_i(counter_clear_n_i[p]),
      .chip_select_low_n_i(chip_select_low_n_i[p]),
      .chip_select_high_i(chip_select_high_i[p]),
      .write_n_i(write_n_i[p]),
      .low_byte_select_n_i(low_byte_select_n_i[p]),
      .high_byte_select_n_i(high_byte_select_n_i[p]),
      .wdata_i(data_i[p*sdpr_pkg::DATA_W +: sdpr_pkg::DATA_W]),
      .addr_o(p_addr[p]),
      .sel_o(p_sel[p]),
      .wr_o(p_wr[p]),
      .lane_o(p_lane[p]),
      .wdata_o(p_wdata[p])
    );
  end

  // ****************************************************************
  // array write
  // ****************************************************************
  // the write happens once per registered request, one cycle wide,
  // independent of clock duty cycle; port 1 is applied last so a
  // same-word collision lands one of the two, which is allowed
  always_ff @(posedge sys_clk_i)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (p_wr[p])
      begin
        mem[p_addr[p]] <= (mem[p_addr[p]] & ~lane_mask(p_lane[p]))
          | (p_wdata[p] & lane_mask(p_lane[p]));
      end
    end
  end

  // ****************************************************************
  // output stage
  // ****************************************************************
  // read from the registered address so both modes see the same word
  logic [sdpr_pkg::DATA_W-1:0] word_now [2];
  always_comb
  begin
    for (int p = 0; p < 2; p++)
      word_now[p] = mem[p_addr[p]];
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rd_r <= '{default: sdpr_pkg::DATA_RST};
      oen_r <= 2'h3;
      sel_d_r <= 2'h0;
      pipe_sel_r <= 2'h0;
      pipe_rd_r <= 2'h0;
      pipe_lane_r <= '{default: 2'h0};
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        rd_r[p] <= word_now[p];
        // output enable is taken with the access, like the select, write and byte lane controls
        oen_r[p] <= output_enable_n_i[p];
        // pipelined drive needs the cycle before the access selected too
        sel_d_r[p] <= p_sel[p];
        pipe_sel_r[p] <= sel_d_r[p];
        pipe_rd_r[p] <= p_sel[p] && !p_wr[p] && !oen_r[p];
        pipe_lane_r[p] <= p_lane[p];
      end
    end
  end

  // outputs are flopped: the flow-through path shows the word one edge
  // after the address edge, the pipelined path one edge later still
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      data_o <= '0;
      data_oe_o <= '0;
      powered_down_o <= 2'h0;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        powered_down_o[p] <= !(!chip_select_low_n_i[p] && chip_select_high_i[p]);
        if (output_mode_select_i[p])
        begin
          data_o[p*sdpr_pkg::DATA_W +: sdpr_pkg::DATA_W] <= rd_r[p];
          data_oe_o[p*sdpr_pkg::DATA_W +: sdpr_pkg::DATA_W] <=
            (pipe_sel_r[p] && pipe_rd_r[p])
            ? lane_mask(pipe_lane_r[p]) : '0;
        end
        else
        begin
          data_o[p*sdpr_pkg::DATA_W +: sdpr_pkg::DATA_W] <= word_now[p];
          data_oe_o[p*sdpr_pkg::DATA_W +: sdpr_pkg::DATA_W] <=
            (p_sel[p] && !p_wr[p] && !oen_r[p])
            ? lane_mask(p_lane[p]) : '0;
        end
      end
    end
  end

  a_oe_needs_oen: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !output_mode_select_i[0] && output_enable_n_i[0]
    |=> ##1 data_oe_o[sdpr_pkg::DATA_W-1:0] == '0)
    else $error("port 0 drove with output enable high");
  a_pipe_reactivate: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    output_mode_select_i[0] && !p_sel[0] |=> ##2 data_oe_o[sdpr_pkg::DATA_W-1:0] == '0)
    else $error("pipelined output driven without a selected cycle");
  a_lane_gate: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !output_mode_select_i[0] && low_byte_select_n_i[0]
    |=> ##1 data_oe_o[sdpr_pkg::BYTE_W-1:0] == '0)
    else $error("port 0 low lane driven while unselected");
  a_write_nodrive: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !output_mode_select_i[0] && !write_n_i[0]
    |=> ##1 data_oe_o[sdpr_pkg::DATA_W-1:0] == '0)
    else $error("port 0 drove data during a write");
  a_deselect_float: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !output_mode_select_i[1] && !chip_select_high_i[1]
    |=> ##1 data_oe_o[2*sdpr_pkg::DATA_W-1:sdpr_pkg::DATA_W] == '0)
    else $error("port 1 drove data while deselected");
  c_flow_read: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !output_mode_select_i[1] && p_sel[1] && !p_wr[1] ##1 data_oe_o[sdpr_pkg::DATA_W]);
  a_power_down: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    chip_select_low_n_i[1] |=> powered_down_o[1])
    else $error("port 1 not powered down");
  c_pipe_read: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    output_mode_select_i[0] && p_sel[0] && !p_wr[0] ##2 data_oe_o[0]);
  c_both_write: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    p_wr[0] && p_wr[1]);
endmodule : sdpr_ram

// ---- tb/sdpr_master.sv ----
// bus master model driving one port of the dual-port ram
`timescale 1ns/1ns
module sdpr_master (
  input wire logic sys_clk_i,
  output logic mode_o,
  output logic [15:0] addr_o,
  output logic addr_strobe_n_o,
  output logic count_enable_n_o,
  output logic counter_clear_n_o,
  output logic write_n_o,
  output logic chip_select_low_n_o,
  output logic chip_select_high_o,
  output logic output_enable_n_o,
  output logic high_byte_select_n_o,
  output logic low_byte_select_n_o,
  output logic [17:0] wdata_o
);
  // ****
  // pin driving
  // ****
  task automatic put(input logic m, input logic [15:0] a, input logic [3:0] c,
    input logic [2:0] e, input logic [1:0] l, input logic [17:0] d);
  begin
    mode_o = m;
    addr_o = a;
    {addr_strobe_n_o, count_enable_n_o, counter_clear_n_o, write_n_o} = c;
    {chip_select_low_n_o, chip_select_high_o, output_enable_n_o} = e;
    {high_byte_select_n_o, low_byte_select_n_o} = l;
    // a released data line flips so a stale value never passes for real data
    wdata_o = write_n_o ? ~wdata_o : d;
  end
  endtask : put
  // one access per call, held for a whole cycle
  task automatic go(input logic m, input logic [15:0] a, input logic [3:0] c,
    input logic [2:0] e, input logic [1:0] l, input logic [17:0] d);
  begin
    @(posedge sys_clk_i);
    #1;
    put(m, a, c, e, l, d);
  end
  endtask : go
  initial
  begin
    wdata_o = '0;
    put(1'b0, '0, 4'hf, 3'h4, 2'h3, '0);
  end
endmodule : sdpr_master

// ---- tb/sdpr_tb_top.sv ----
// self-checking bench for the dual-port burst ram
`timescale 1ns/1ns
module sdpr_tb_top;
  localparam logic [3:0] WR = 4'h6;
  localparam logic [3:0] RD = 4'h7;
  localparam logic [3:0] BW = 4'ha;
  localparam logic [3:0] BR = 4'hb;
  localparam logic [3:0] NOP = 4'hf;
  localparam logic [2:0] ON = 3'h2;
  localparam logic [3:0] BC [7] = '{RD, BR, BR, BR, 4'h1, 4'h3, NOP};
  localparam logic [15:0] BA [7] = '{16'hfffe, 16'h7, 16'h7, 16'h7, 16'h5, 16'h5, 16'h9};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] mode, addr_strobe_n, cnt, clr, wrn, csl, csh, oen, ubn, lbn, pdn;
  logic [31:0] addr;
  logic [35:0] wd, rd, oe;
  logic [17:0] mem [int];
  logic [17:0] xd [2][8];
  logic [17:0] xo [2][8];
  logic [1:0] xp [8];
  logic [15:0] cnt_r [2];
  logic [1:0] psel;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  sdpr_ram sdpr_ram_i (
    .sys_clk_i(clk), .arst_n_i(arst_n), .output_mode_select_i(mode), .addr_i(addr),
    .addr_strobe_n_i(addr_strobe_n), .count_enable_n_i(cnt), .counter_clear_n_i(clr),
    .chip_select_low_n_i(csl), .chip_select_high_i(csh), .write_n_i(wrn),
    .low_byte_select_n_i(lbn), .high_byte_select_n_i(ubn), .output_enable_n_i(oen),
    .data_i(wd), .data_o(rd), .data_oe_o(oe), .powered_down_o(pdn));
  for (genvar g = 0; g < 2; g++)
  begin : gm
    sdpr_master sdpr_master_i (
      .sys_clk_i(clk), .mode_o(mode[g]), .addr_o(addr[g*16+:16]), .addr_strobe_n_o(addr_strobe_n[g]),
      .count_enable_n_o(cnt[g]), .counter_clear_n_o(clr[g]), .write_n_o(wrn[g]),
      .chip_select_low_n_o(csl[g]), .chip_select_high_o(csh[g]), .output_enable_n_o(oen[g]),
      .high_byte_select_n_o(ubn[g]), .low_byte_select_n_o(lbn[g]), .wdata_o(wd[g*18+:18]));
  end
  // ****
  // reference model
  // ****
  task automatic step(input int p);
    logic s;
    logic [15:0] a;
    logic [1:0] dr;
  begin
    s = !csl[p] && csh[p];
    a = !clr[p] ? 16'h0000 : !addr_strobe_n[p] ? addr[p*16+:16] : !cnt[p] ? cnt_r[p] + 16'h0001 : cnt_r[p];
    cnt_r[p] = a;
    if (s && !wrn[p] && !lbn[p])
      mem[a][8:0] = wd[p*18+:9];
    if (s && !wrn[p] && !ubn[p])
      mem[a][17:9] = wd[p*18+9+:9];
    dr = {2{s && wrn[p] && !oen[p] && (!mode[p] || psel[p])}} & ~{ubn[p], lbn[p]};
    xo[p][(cyc + 1 + mode[p]) % 8] = {{9{dr[1]}}, {9{dr[0]}}};
    xd[p][(cyc + 1 + mode[p]) % 8] = mem[a];
    xp[cyc % 8][p] = !s;
    psel[p] = s;
  end
  endtask : step
  always @(posedge clk)
  begin
    if (arst_n)
    begin
      cyc++;
      for (int p = 0; p < 2; p++)
        step(p);
    end
  end
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] s);
  begin
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  end
  endtask : chk
  always @(negedge clk)
  begin
    if (arst_n && cyc > 2)
    begin
      for (int p = 0; p < 2; p++)
      begin
        chk("drive", xo[p][cyc % 8], oe[p*18+:18]);
        chk("rdata", xd[p][cyc % 8] & xo[p][cyc % 8], rd[p*18+:18] & xo[p][cyc % 8]);
        chk("pdown", {17'h0, xp[cyc % 8][p]}, {17'h0, pdn[p]});
        xo[p][cyc % 8] = '0;
      end
    end
  end
  // ****
  // stimulus
  // ****
  function automatic logic [17:0] rnd();
    return 18'($urandom());
  endfunction : rnd
  task automatic pair(input logic m, input logic [15:0] a0, a1, input logic [3:0] c0, c1,
    input logic [2:0] e0, e1, input logic [1:0] l0, l1, input logic [17:0] d0, d1);
  begin
    fork
      gm[0].sdpr_master_i.go(m, a0, c0, e0, l0, d0);
      gm[1].sdpr_master_i.go(m, a1, c1, e1, l1, d1);
    join
  end
  endtask : pair
  task automatic print_verdict;
  begin
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask : print_verdict
  initial
  begin
    foreach (xo[p, s])
      xo[p][s] = '0;
    foreach (xp[s])
      xp[s] = '0;
    cnt_r = '{default: '0};
    psel = '0;
    void'($urandom(32'hf6bb));
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    // the two ports never write one word in the same cycle
    for (int i = 0; i < 8; i++)
      pair(1'b0, 16'(i), 16'(i + 16), WR, WR, ON, ON, 2'h0, 2'h0, rnd(), rnd());
    for (int i = 0; i < 9; i++)
      pair(1'b0, 16'(i % 8 + 16), 16'(i % 8), RD, RD, ON, ON, 0, 0, rnd(), rnd());
    $display("test 1 done");
    for (int i = 0; i < 4; i++)
      pair(1'b0, 16'(i), 16'(i), WR, WR, ON, 3'(i % 2 * 6), 2'(i), 0, rnd(), rnd());
    for (int i = 0; i < 4; i++)
      pair(1'b0, 16'(i), 16'(3 - i), RD, RD, 3'(i == 2 ? 3 : 2), ON, 2'(3 - i), 2'(i), 0, 0);
    $display("test 2 done");
    pair(1'b0, 16'hfffe, 16'h0, WR, NOP, ON, 3'h4, 2'h0, 2'h0, rnd(), rnd());
    repeat (3)
      pair(1'b0, 16'h1234, 16'h0, BW, NOP, ON, 3'h4, 2'h0, 2'h0, rnd(), rnd());
    foreach (BC[i])
      pair(1'b0, 16'h0, BA[i], NOP, BC[i], 3'h4, ON, 2'h0, 2'h0, 0, 0);
    $display("test 3 done");
    repeat (3)
      pair(1'b0, 16'h0, 16'h0, NOP, NOP, 3'h4, 3'h0, 2'h0, 2'h0, 0, 0);
    for (int i = 0; i < 6; i++)
      pair(1'b1, 16'h0, 16'h10, i ? BR : RD, i ? BR : RD, ON, ON, 0, 0, 0, 0);
    repeat (4)
      pair(1'b1, 16'h0, 16'h0, NOP, NOP, 3'h4, 3'h4, 2'h0, 2'h0, 0, 0);
    $display("test 4 done");
    print_verdict();
  end
  initial
  begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule : sdpr_tb_top
